//--- rtl/pcw_regs.svh
// Purpose: offsets, field positions, reset values of the pwm cycle config register
// Assumes: 8-bit special function register space
// Notes:   included by pcw_cycle_config; the package carries the types only
`ifndef PCW_REGS_SVH
`define PCW_REGS_SVH
`define PCW_CFG_ADDR        8'hf7
`define PCW_CFG_RESET       8'h00
`define PCW_BIT_BANK_SEL    7
`define PCW_BIT_IRQ_EN      6
`define PCW_BIT_WRAP_FLAG   5
`define PCW_UNUSED_HI       4
`define PCW_UNUSED_LO       2
`define PCW_CLSEL_HI        1
`define PCW_CLSEL_LO        0
`define PCW_BITS_8          5'h08
`define PCW_BITS_9          5'h09
`define PCW_BITS_10         5'h0a
`define PCW_BITS_11         5'h0b
`define PCW_BITS_16         5'h10
`define PCW_BITS_NONE       5'h00
`endif

//--- rtl/pcw_pkg.sv
// Purpose: shared types of the pwm cycle config block
// Assumes: constants live in pcw_regs.svh
// Notes:   no imports; use pcw_pkg::name
package pcw_pkg;

  typedef enum logic [1:0]
  {
    PCW_LEN_8  = 2'b00,
    PCW_LEN_9  = 2'b01,
    PCW_LEN_10 = 2'b10,
    PCW_LEN_11 = 2'b11
  } pcw_len_t;

  // per-channel mode bits as held by the module mode registers
  typedef struct packed
  {
    logic wide_pwm_enable;
    logic pwm_enable;
  } pcw_chan_mode_t;

  // per-channel effective pwm setup handed to the compare logic
  typedef struct packed
  {
    logic [4:0] cycle_bits;
    logic       reload_active;
  } pcw_chan_cfg_t;

endpackage : pcw_pkg

//--- rtl/pcw_cycle_config.sv
// Purpose: pwm cycle configuration and status register of a counter array
// Assumes: counter value and advance pulse arrive on clk_sys, no sync needed
// Notes:   read data is registered, one cycle after the read strobe
//
// Notes on behaviour
// - bank select routes module value accesses
// - reload values used only in 9-11 bit
// - irq when flag set and enabled
// - counter wrap at selected bit sets flag
// - software may set flag; only software clears
// - codes 00/10/11 give 8/10/11 bits
// - length applies to non-16-bit pwm channels
// - bits 4:2 read zero, ignore writes
// - wide enable selects 16-bit pwm
`timescale 1ns/1ps
`include "pcw_regs.svh"

module pcw_cycle_config #(
  parameter int N_CH = 3
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  // special function register bus
  input  wire logic [7:0]                 sfr_addr,
  input  wire logic                       sfr_wr,
  input  wire logic [7:0]                 sfr_wdata,
  input  wire logic                       sfr_rd,
  output logic      [7:0]                 sfr_rdata_q,
  output logic                            sfr_hit_q,
  // main counter
  input  wire logic [15:0]                array_main_counter,
  input  wire logic                       counter_advance,
  // module value address routing
  input  wire logic                       module_value_access,
  output logic                            route_to_compare,
  output logic                            route_to_reload,
  // per-channel modes and effective setup
  input  pcw_pkg::pcw_chan_mode_t [N_CH-1:0] chan_mode,
  output pcw_pkg::pcw_chan_cfg_t  [N_CH-1:0] chan_cfg,
  // configuration outputs
  output logic                            reload_bank_select,
  output pcw_pkg::pcw_len_t               cycle_length_select,
  output logic                            cycle_wrap_flag,
  output logic                            cycle_wrap_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [4:0] len_bits(input pcw_pkg::pcw_len_t sel);
    case (sel)
      pcw_pkg::PCW_LEN_8:  len_bits = `PCW_BITS_8;
      pcw_pkg::PCW_LEN_9:  len_bits = `PCW_BITS_9;
      pcw_pkg::PCW_LEN_10: len_bits = `PCW_BITS_10;
      pcw_pkg::PCW_LEN_11: len_bits = `PCW_BITS_11;
      default:             len_bits = `PCW_BITS_8;
    endcase
  endfunction : len_bits

  // true when the counter is about to carry out of the selected bit
  function automatic logic at_wrap(input pcw_pkg::pcw_len_t sel, input logic [15:0] cnt);
    case (sel)
      pcw_pkg::PCW_LEN_8:  at_wrap = &cnt[7:0];
      pcw_pkg::PCW_LEN_9:  at_wrap = &cnt[8:0];
      pcw_pkg::PCW_LEN_10: at_wrap = &cnt[9:0];
      pcw_pkg::PCW_LEN_11: at_wrap = &cnt[10:0];
      default:             at_wrap = 1'b0;
    endcase
  endfunction : at_wrap

  // one decoder for both strobes so reads and writes never disagree on the address
  function automatic logic is_cfg_addr(input logic [7:0] addr);
    is_cfg_addr = (addr == `PCW_CFG_ADDR);
  endfunction : is_cfg_addr

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic              bank_sel_q;
  logic              irq_en_q;
  logic              wrap_flag_q;
  logic              wrap_flag_d;
  pcw_pkg::pcw_len_t len_sel_q;
  logic              cfg_wr;
  logic              wrap_event;
  logic [7:0]        read_value;
  logic              cfg_rd;

  assign cfg_wr     = sfr_wr && is_cfg_addr(sfr_addr);
  assign cfg_rd     = sfr_rd && is_cfg_addr(sfr_addr);
  // the advance pulse qualifies the wrap so a stalled counter flags only once
  // limitation: a counter loaded onto all ones and then advanced counts as a wrap,
  // since the flag follows the carry condition, not the history of the count
  assign wrap_event = counter_advance && at_wrap(len_sel_q, array_main_counter);

  // unused bits 4:2 have no storage, so writes there vanish
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      bank_sel_q <= 1'b0;
    end
    else if (cfg_wr)
    begin
      bank_sel_q <= sfr_wdata[`PCW_BIT_BANK_SEL];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      irq_en_q <= 1'b0;
    end
    else if (cfg_wr)
    begin
      irq_en_q <= sfr_wdata[`PCW_BIT_IRQ_EN];
    end
  end

  // a new length moves the wrap check from the next cycle on
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      len_sel_q <= pcw_pkg::PCW_LEN_8;
    end
    else if (cfg_wr)
    begin
      len_sel_q <= pcw_pkg::pcw_len_t'(sfr_wdata[`PCW_CLSEL_HI:`PCW_CLSEL_LO]);
    end
  end

  // a hardware wrap in the same cycle as a clearing write still sets the flag
  always_comb
  begin
    wrap_flag_d = wrap_flag_q;
    if (cfg_wr)
    begin
      wrap_flag_d = sfr_wdata[`PCW_BIT_WRAP_FLAG];
    end
    if (wrap_event)
    begin
      wrap_flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      wrap_flag_q <= 1'b0;
    end
    else
    begin
      wrap_flag_q <= wrap_flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb
  begin
    read_value = `PCW_CFG_RESET;
    read_value[`PCW_BIT_BANK_SEL]           = bank_sel_q;
    read_value[`PCW_BIT_IRQ_EN]             = irq_en_q;
    read_value[`PCW_BIT_WRAP_FLAG]          = wrap_flag_q;
    read_value[`PCW_UNUSED_HI:`PCW_UNUSED_LO] = 3'h0;
    read_value[`PCW_CLSEL_HI:`PCW_CLSEL_LO] = len_sel_q;
  end

  // other addresses return zero with the hit flag low
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q   <= 1'b0;
    end
    else if (cfg_rd)
    begin
      sfr_rdata_q <= read_value;
      sfr_hit_q   <= 1'b1;
    end
    else
    begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the rest of the array

  assign route_to_compare    = module_value_access && !bank_sel_q;
  assign route_to_reload     = module_value_access && bank_sel_q;
  assign reload_bank_select  = bank_sel_q;
  assign cycle_length_select = len_sel_q;
  assign cycle_wrap_flag     = wrap_flag_q;
  assign cycle_wrap_irq      = wrap_flag_q && irq_en_q;

  // channel setup is combinational so a mode change takes effect at once
  genvar ch;
  generate
    for (ch = 0; ch < N_CH; ch++)
    begin : g_chan
      always_comb
      begin
        if (!chan_mode[ch].pwm_enable)
        begin
          chan_cfg[ch].cycle_bits    = `PCW_BITS_NONE;
          chan_cfg[ch].reload_active = 1'b0;
        end
        else if (chan_mode[ch].wide_pwm_enable)
        begin
          chan_cfg[ch].cycle_bits    = `PCW_BITS_16;
          chan_cfg[ch].reload_active = 1'b0;
        end
        else
        begin
          chan_cfg[ch].cycle_bits    = len_bits(len_sel_q);
          chan_cfg[ch].reload_active = (len_sel_q != pcw_pkg::PCW_LEN_8);
        end
      end
    end
  endgenerate

endmodule : pcw_cycle_config

//--- verification/pcw_props.sv
// Purpose: port assertions for pcw_cycle_config
// Assumes: one clock, sync active-low reset
// Notes:   ports grouped several to a line to stay compact
`timescale 1ns/1ps
module pcw_props #(parameter int N_CH = 3) (
  // bus
  input wire logic        clk_sys, resetn, sfr_wr, sfr_rd, sfr_hit_q,
  input wire logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_q,
  // counter and outputs
  input wire logic [15:0] array_main_counter,
  input wire logic        counter_advance, module_value_access, route_to_compare,
  input wire logic        route_to_reload, reload_bank_select, cycle_wrap_flag, cycle_wrap_irq,
  input pcw_pkg::pcw_len_t                 cycle_length_select,
  input pcw_pkg::pcw_chan_mode_t [N_CH-1:0] chan_mode,
  input pcw_pkg::pcw_chan_cfg_t  [N_CH-1:0] chan_cfg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // low bits that must be all ones for a cycle wrap
  wire logic [15:0] low = (16'h0100 << cycle_length_select) - 16'h0001;
  wire logic wrap = counter_advance && ((array_main_counter & low) == low);
  wire logic hit = sfr_wr && sfr_addr == 8'hf7;
  wire logic [1:0] m0 = chan_mode[0];
  sequence s_hit; hit; endsequence
  sequence s_wrap; wrap; endsequence
  property p_route;
    module_value_access |->
      route_to_reload == reload_bank_select && route_to_compare != route_to_reload;
  endproperty
  property p_len;
    s_hit |=> cycle_length_select == $past(sfr_wdata[1:0])
      && reload_bank_select == $past(sfr_wdata[7]);
  endproperty
  property p_irq; s_hit |=> cycle_wrap_irq == ($past(sfr_wdata[6]) && cycle_wrap_flag); endproperty
  property p_wrap; s_wrap |=> cycle_wrap_flag; endproperty
  // set beats clear when a wrap meets a clearing write
  property p_sw; s_hit |=> cycle_wrap_flag == $past(sfr_wdata[5] || wrap); endproperty
  property p_keep; !hit |=> cycle_wrap_flag == $past(cycle_wrap_flag || wrap); endproperty
  property p_rd; sfr_rd |=> sfr_hit_q == $past(sfr_addr == 8'hf7) && sfr_rdata_q[4:2] == 3'h0;
  endproperty
  property p_cfg;
    m0 == 2'b01 |->
      chan_cfg[0] == {5'h08 + {3'h0, cycle_length_select}, cycle_length_select != 2'b00};
  endproperty
  property p_wide; m0 == 2'b11 |-> chan_cfg[0] == 6'h20; endproperty
  a_route: assert property (p_route) else $error("route wrong");
  a_len: assert property (p_len) else $error("length or bank wrong");
  a_irq: assert property (p_irq) else $error("irq wrong");
  a_wrap: assert property (p_wrap) else $error("wrap not flagged");
  a_sw: assert property (p_sw) else $error("flag write wrong");
  a_keep: assert property (p_keep) else $error("flag changed alone");
  a_rd: assert property (p_rd) else $error("read wrong");
  a_cfg: assert property (p_cfg) else $error("cfg wrong");
  a_wide: assert property (p_wide) else $error("wide cfg wrong");
endmodule : pcw_props
bind pcw_cycle_config pcw_props #(.N_CH(N_CH)) pcw_props_inst (.*);

//--- verification/pwm_cycle_config_test.sv
// Purpose: self-checking bench for pcw_cycle_config
// Assumes: 125 MHz clk_sys, sync active-low reset
// Notes:   read data checked against a queue of notes
`timescale 1ns/1ps
module pwm_cycle_config_test;
  logic clk_sys = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic counter_advance = 1'b0, module_value_access = 1'b0, sfr_hit_q, cycle_wrap_flag;
  logic route_to_compare, route_to_reload, reload_bank_select, cycle_wrap_irq;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_q, v;
  logic [15:0] array_main_counter = 16'h0000, ones;
  pcw_pkg::pcw_len_t cycle_length_select;
  pcw_pkg::pcw_chan_mode_t [2:0] chan_mode = '0;
  pcw_pkg::pcw_chan_cfg_t [2:0] chan_cfg;
  logic [7:0] expq[$];
  logic [31:0] seed = 32'h1ed0;
  int n_errors = 0, comparisons = 0;
  pcw_cycle_config #(.N_CH(3)) pcw_cycle_config_inst
  (
    .clk_sys             (clk_sys),
    .resetn              (resetn),
    .sfr_addr            (sfr_addr),
    .sfr_wr              (sfr_wr),
    .sfr_wdata           (sfr_wdata),
    .sfr_rd              (sfr_rd),
    .sfr_rdata_q         (sfr_rdata_q),
    .sfr_hit_q           (sfr_hit_q),
    .array_main_counter  (array_main_counter),
    .counter_advance     (counter_advance),
    .module_value_access (module_value_access),
    .route_to_compare    (route_to_compare),
    .route_to_reload     (route_to_reload),
    .chan_mode           (chan_mode),
    .chan_cfg            (chan_cfg),
    .reload_bank_select  (reload_bank_select),
    .cycle_length_select (cycle_length_select),
    .cycle_wrap_flag     (cycle_wrap_flag),
    .cycle_wrap_irq      (cycle_wrap_irq)
  );
  initial forever #4 clk_sys = ~clk_sys;
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    @(negedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] e);
    @(posedge clk_sys);
    sfr_addr <= 8'hf7;
    sfr_rd <= 1'b1;
    expq.push_back(e);
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
  endtask : rd
  task automatic adv(input logic [15:0] c);
    @(posedge clk_sys);
    array_main_counter <= c;
    counter_advance <= 1'b1;
    @(posedge clk_sys);
    counter_advance <= 1'b0;
    @(negedge clk_sys);
  endtask : adv
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [7:0] cfg(input logic [1:0] m, l);
    if (!m[0]) return 8'h00;
    if (m[1]) return 8'h20;
    return {2'b00, 5'h08 + {3'h0, l}, l != 2'b00};
  endfunction : cfg
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
    if (sfr_hit_q === 1'b1)
      check("rdata", sfr_rdata_q, expq.pop_front());
  initial
  begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h00);
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr_next(seed);
      v = seed[7:0];
      chan_mode <= seed[13:8];
      module_value_access <= seed[14];
      wr(8'hf7, v);
      check("irq", 8'(cycle_wrap_irq), 8'(v[6] & v[5]));
      check("reload", 8'(route_to_reload), 8'(seed[14] & v[7]));
      check("compare", 8'(route_to_compare), 8'(seed[14] & !v[7]));
      check("bank", 8'(reload_bank_select), 8'(v[7]));
      check("len", 8'(cycle_length_select), 8'(v[1:0]));
      for (int c = 0; c < 3; c++)
        check("cfg", 8'(chan_cfg[c]), cfg(seed[8+2*c +: 2], v[1:0]));
      rd(v & 8'he3);
    end
    // a write elsewhere must leave the register alone
    wr(8'hf6, 8'hff);
    rd(v & 8'he3);
    // a reset in mid-run must bring every field back to zero
    wr(8'hf7, 8'hff);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    check("rstirq", 8'(cycle_wrap_irq), 8'h00);
    check("rstbank", 8'(reload_bank_select), 8'h00);
    rd(8'h00);
    // a read elsewhere must leave the hit flag and the data low
    @(posedge clk_sys);
    sfr_addr <= 8'hf6;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    @(negedge clk_sys);
    check("hitother", 8'(sfr_hit_q), 8'h00);
    check("rdother", sfr_rdata_q, 8'h00);
    for (int l = 0; l < 4; l++)
    begin
      ones = (16'h0100 << l) - 16'h0001;
      wr(8'hf7, 8'(l));
      adv(ones >> 1);
      check("nowrap", 8'(cycle_wrap_flag), 8'h00);
      adv(ones);
      check("wrap", 8'(cycle_wrap_flag), 8'h01);
      check("masked", 8'(cycle_wrap_irq), 8'h00);
      fork
        wr(8'hf7, 8'h40 + 8'(l));
        adv(ones);
      join
      check("setwins", 8'(cycle_wrap_irq), 8'h01);
      adv(16'h0000);
      check("held", 8'(cycle_wrap_flag), 8'h01);
    end
    check("pending", 8'(expq.size()), 8'h00);
    print_verdict();
  end
  // the scenarios need under 200 cycles; fifteen times that means a hang
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end
endmodule : pwm_cycle_config_test
